/* rrbx_pkg.sv */
// Package with constants for the rotate, return and bank execution block.
// Notes on behaviour
// - The carry-clear opcode CF, one byte and 4 cycles, forces carry to 0 and leaves all other flags alone.
// - Return loads the program counter from the stack, then adds two to the stack pointer, and changes no flags.
// - Return is the single opcode AF and takes 8 cycles, or 10 in the alternate stack configuration.
// - Rotate-left (90 direct, 91 indirect) copies old bit 7 into bit 0 and carry, two bytes and 4 cycles.
// - Rotate-left sets zero and sign from the result, overflow on sign change, and keeps decimal and half flags.
// - Rotate-left-through-carry (10, 11) loads bit 0 from old carry and carry from old bit 7 in 4 cycles.
// - Rotate-right (E0, E1) copies old bit 0 into bit 7 and carry in 4 cycles.
// - Rotate-right-through-carry (C0, C1) loads bit 7 from old carry and carry from old bit 0 in 4 cycles.
// - For the carry-through and right rotates, overflow is set exactly when bit 7 changed.
// - For those rotates, zero and sign follow the result and decimal and half flags stay unchanged.
// - Select-bank-0 (4F, 4 cycles) clears flags bit 0 and changes no condition flag.
// - Select-bank-1 (5F, 4 cycles) sets flags bit 0 and changes no condition flag.
package rrbx_pkg;
  localparam logic [7:0] RRBX_OP_CARRY_CLEAR = 8'hCF;
  localparam logic [7:0] RRBX_OP_RETURN = 8'hAF;
  localparam logic [7:0] RRBX_OP_ROT_LEFT = 8'h90;
  localparam logic [7:0] RRBX_OP_ROT_LEFT_C = 8'h10;
  localparam logic [7:0] RRBX_OP_ROT_RIGHT = 8'hE0;
  localparam logic [7:0] RRBX_OP_ROT_RIGHT_C = 8'hC0;
  localparam logic [7:0] RRBX_OP_BANK_ZERO = 8'h4F;
  localparam logic [7:0] RRBX_OP_BANK_ONE = 8'h5F;
  // Flag bit positions inside the flags register.
  localparam int RRBX_FLAG_C = 7;
  localparam int RRBX_FLAG_Z = 6;
  localparam int RRBX_FLAG_S = 5;
  localparam int RRBX_FLAG_V = 4;
  localparam int RRBX_FLAG_BANK = 0;
  // Cycle counts per instruction.
  localparam logic [3:0] RRBX_CYC_SHORT = 4'h4;
  localparam logic [3:0] RRBX_CYC_RET_INT = 4'h8;
  localparam logic [3:0] RRBX_CYC_RET_EXT = 4'hA;
  localparam logic [15:0] RRBX_STACK_STEP = 16'h0002;
  // Avalon register offsets in bytes.
  localparam logic [3:0] RRBX_ADDR_CTRL = 4'h0;
  localparam logic [3:0] RRBX_ADDR_STATUS = 4'h4;
  localparam logic [3:0] RRBX_ADDR_FLAGS = 4'h8;
  localparam logic [3:0] RRBX_ADDR_PC = 4'hC;
  localparam logic [7:0] RRBX_FLAGS_RESET = 8'h00;
  localparam logic [15:0] RRBX_SP_RESET = 16'h0000;
  localparam logic [15:0] RRBX_PC_RESET = 16'h0000;
  localparam logic [31:0] RRBX_UNMAPPED = 32'h00000000;
  typedef enum logic [2:0]
  {
    RRBX_IDLE = 3'b000,
    RRBX_FETCH_OPR = 3'b001,
    RRBX_FETCH_IND = 3'b011,
    RRBX_FETCH_VAL = 3'b010,
    RRBX_STACK_HI = 3'b110,
    RRBX_STACK_LO = 3'b111,
    RRBX_WAIT = 3'b101
  } rrbx_state_t;
endpackage

/* rrbx_rotator.sv */
// Combinational rotate unit with flag results.
`timescale 1ns/1ns
module rrbx_rotator
(
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic carry_out,
  output logic zero_out,
  output logic sign_out,
  output logic overflow_out
);
  import rrbx_pkg::*;
  always_comb
  begin
    case ({opcode[7:1], 1'b0})
      RRBX_OP_ROT_LEFT:
      begin
        result = {operand[6:0], operand[7]};
        carry_out = operand[7];
      end
      RRBX_OP_ROT_LEFT_C:
      begin
        result = {operand[6:0], carry_in};
        carry_out = operand[7];
      end
      RRBX_OP_ROT_RIGHT:
      begin
        result = {operand[0], operand[7:1]};
        carry_out = operand[0];
      end
      RRBX_OP_ROT_RIGHT_C:
      begin
        result = {carry_in, operand[7:1]};
        carry_out = operand[0];
      end
      default:
      begin
        result = operand;
        carry_out = carry_in;
      end
    endcase
    zero_out = (result == 8'h00);
    sign_out = result[7];
    overflow_out = result[7] ^ operand[7];
  end
endmodule

/* rrbx_exec.sv */
// Execution unit for carry-clear, return, rotates and bank selection.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module rrbx_exec
#(
  parameter bit EXT_STACK = 1'b0
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic [7:0] rf_addr,
  output logic rf_we,
  output logic [7:0] rf_wdata,
  input wire logic [7:0] rf_rdata,
  output logic busy
);
  import rrbx_pkg::*;
  rrbx_state_t state_reg;
  logic [7:0] opcode_reg;
  logic [7:0] operand_reg;
  logic [7:0] flags_reg;
  logic [15:0] pc_reg;
  logic [15:0] sp_reg;
  logic [3:0] cyc_reg;
  logic [7:0] done_count_reg;
  logic avs_ack_reg;
  logic [7:0] rot_result;
  logic rot_c;
  logic rot_z;
  logic rot_s;
  logic rot_v;
  logic issue;
  logic wait_done;
  logic [3:0] ret_cycles;
  logic dec_rot;
  logic dec_ret;
  logic [7:0] dec_op;
  logic [31:0] read_word;

  //////////////////////////////////////////////////////////////////////
  // Software writes an opcode and operand byte into the control word.
  // A write lands only at the edge where waitrequest is seen low, which is
  // the one cycle in which the ack register is high.
  assign issue = avs_write && avs_ack_reg && avs_address == RRBX_ADDR_CTRL
    && state_reg == RRBX_IDLE;
  assign wait_done = cyc_reg <= 4'h1;
  assign ret_cycles = EXT_STACK ? RRBX_CYC_RET_EXT : RRBX_CYC_RET_INT;

  rrbx_rotator u_rot
  (
    .opcode(opcode_reg),
    .operand(rf_rdata),
    .carry_in(flags_reg[RRBX_FLAG_C]),
    .result(rot_result),
    .carry_out(rot_c),
    .zero_out(rot_z),
    .sign_out(rot_s),
    .overflow_out(rot_v)
  );

  //////////////////////////////////////////////////////////////////////
  // Opcode decode of the control word; the low bit of a rotate only picks
  // the indirect form, so it is masked before the compare.
  always_comb
  begin
    dec_op = avs_writedata[7:0];
    dec_rot = 1'b0;
    case ({dec_op[7:1], 1'b0})
      RRBX_OP_ROT_LEFT,
      RRBX_OP_ROT_LEFT_C,
      RRBX_OP_ROT_RIGHT,
      RRBX_OP_ROT_RIGHT_C:
      begin
        dec_rot = 1'b1;
      end
      default:
      begin
        dec_rot = 1'b0;
      end
    endcase
    dec_ret = dec_op == RRBX_OP_RETURN;
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= RRBX_IDLE;
      opcode_reg <= 8'h00;
      operand_reg <= 8'h00;
      cyc_reg <= 4'h0;
    end
    else if (clk_en)
    begin
      case (state_reg)
        RRBX_IDLE:
        begin
          if (issue)
          begin
            opcode_reg <= avs_writedata[7:0];
            operand_reg <= avs_writedata[15:8];
            if (dec_ret)
            begin
              cyc_reg <= ret_cycles - 4'h2;
              state_reg <= RRBX_STACK_HI;
            end
            else if (dec_rot)
            begin
              cyc_reg <= RRBX_CYC_SHORT - 4'h1;
              state_reg <= avs_writedata[0] ? RRBX_FETCH_IND
                : RRBX_FETCH_OPR;
            end
            else
            begin
              cyc_reg <= RRBX_CYC_SHORT - 4'h1;
              state_reg <= RRBX_WAIT;
            end
          end
        end
        RRBX_FETCH_IND:
        begin
          operand_reg <= rf_rdata;
          cyc_reg <= cyc_reg - 4'h1;
          state_reg <= RRBX_FETCH_OPR;
        end
        RRBX_FETCH_OPR:
        begin
          cyc_reg <= cyc_reg - 4'h1;
          state_reg <= RRBX_WAIT;
        end
        RRBX_STACK_HI:
        begin
          cyc_reg <= cyc_reg - 4'h1;
          state_reg <= RRBX_STACK_LO;
        end
        RRBX_STACK_LO:
        begin
          state_reg <= RRBX_WAIT;
        end
        RRBX_WAIT:
        begin
          if (wait_done)
          begin
            state_reg <= RRBX_IDLE;
          end
          else
          begin
            cyc_reg <= cyc_reg - 4'h1;
          end
        end
        default:
        begin
          state_reg <= RRBX_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Flags are written by the instruction that owns each bit, and as a whole by a software write to the flags word.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flags_reg <= RRBX_FLAGS_RESET;
    end
    else if (clk_en)
    begin
      if (state_reg == RRBX_IDLE && issue)
      begin
        if (avs_writedata[7:0] == RRBX_OP_CARRY_CLEAR)
        begin
          flags_reg[RRBX_FLAG_C] <= 1'b0;
        end
        else if (avs_writedata[7:0] == RRBX_OP_BANK_ZERO)
        begin
          flags_reg[RRBX_FLAG_BANK] <= 1'b0;
        end
        else if (avs_writedata[7:0] == RRBX_OP_BANK_ONE)
        begin
          flags_reg[RRBX_FLAG_BANK] <= 1'b1;
        end
      end
      else if (state_reg == RRBX_FETCH_OPR)
      begin
        flags_reg[RRBX_FLAG_C] <= rot_c;
        flags_reg[RRBX_FLAG_Z] <= rot_z;
        flags_reg[RRBX_FLAG_S] <= rot_s;
        flags_reg[RRBX_FLAG_V] <= rot_v;
      end
      else if (avs_ack_reg && avs_write &&
        avs_address == RRBX_ADDR_FLAGS)
      begin
        flags_reg <= avs_writedata[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // The stack pointer is loaded by software; return advances it by two.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pc_reg <= RRBX_PC_RESET;
      sp_reg <= RRBX_SP_RESET;
    end
    else if (clk_en)
    begin
      if (state_reg == RRBX_STACK_HI)
      begin
        pc_reg[15:8] <= mem_rdata;
      end
      else if (state_reg == RRBX_STACK_LO)
      begin
        pc_reg[7:0] <= mem_rdata;
        sp_reg <= sp_reg + RRBX_STACK_STEP;
      end
      else if (avs_ack_reg && avs_write && avs_address == RRBX_ADDR_PC)
      begin
        pc_reg <= avs_writedata[15:0];
        sp_reg <= avs_writedata[31:16];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Memory and register-file strobes are registered ahead of their use.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mem_addr <= 16'h0000;
      mem_rd <= 1'b0;
      rf_addr <= 8'h00;
      rf_we <= 1'b0;
      rf_wdata <= 8'h00;
      busy <= 1'b0;
    end
    else if (clk_en)
    begin
      rf_we <= 1'b0;
      mem_rd <= 1'b0;
      busy <= state_reg != RRBX_IDLE || issue;
      if (issue)
      begin
        rf_addr <= avs_writedata[15:8];
        mem_addr <= sp_reg;
        mem_rd <= dec_ret;
      end
      else if (state_reg == RRBX_FETCH_IND)
      begin
        rf_addr <= rf_rdata;
      end
      else if (state_reg == RRBX_STACK_HI)
      begin
        mem_addr <= sp_reg + 16'h0001;
        mem_rd <= 1'b1;
      end
      else if (state_reg == RRBX_FETCH_OPR)
      begin
        rf_we <= 1'b1;
        rf_wdata <= rot_result;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Avalon slave: every access answers one cycle after it is presented.
  always_comb
  begin
    case (avs_address)
      RRBX_ADDR_CTRL:
        read_word = {16'h0000, operand_reg, opcode_reg};
      RRBX_ADDR_STATUS:
        read_word = {16'h0000, done_count_reg, 7'h00,
          state_reg != RRBX_IDLE};
      RRBX_ADDR_FLAGS:
        read_word = {24'h000000, flags_reg};
      RRBX_ADDR_PC:
        read_word = {sp_reg, pc_reg};
      default:
        read_word = RRBX_UNMAPPED;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      avs_ack_reg <= 1'b0;
      avs_readdata <= 32'h00000000;
    end
    else if (clk_en)
    begin
      avs_ack_reg <= (avs_read || avs_write) && !avs_ack_reg;
      // Read data is latched on the first edge so that it stands at the
      // edge where the master sees waitrequest low.
      if (avs_read && !avs_ack_reg)
      begin
        avs_readdata <= read_word;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Completed instructions are counted so software can poll for progress;
  // the count wraps silently after 255.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      done_count_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      if (state_reg == RRBX_WAIT && wait_done)
      begin
        done_count_reg <= done_count_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
    end
    else if (clk_en)
    begin
      avs_waitrequest <= !((avs_read || avs_write) && !avs_ack_reg);
    end
  end
endmodule

/* rrbx_exec_checker.sv */
// Concurrent assertions on the ports of the execution unit.
`timescale 1ns/1ns
module rrbx_exec_checker
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic rf_we,
  input wire logic busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic idle_q;
  logic go;
  logic rot;
  logic [7:0] op;
  ////////////////////////////////////////////////////////////////////////
  // An opcode counts only if nothing was running, since busy writes are
  // dropped.
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      idle_q <= 1'b1;
    else
      idle_q <= !busy;
  assign op = avs_writedata[7:0];
  assign go = avs_write && !avs_waitrequest && avs_address == 4'h0 && idle_q;
  assign rot = (op & 8'hFE) inside {8'h90, 8'h10, 8'hE0, 8'hC0};
  ////////////////////////////////////////////////////////////////////////
  AST_CLEAR_QUIET: assert property (go && op == 8'hCF |=>
    (!rf_we && !mem_rd)[*4]) else $error("carry clear touched memory");
  AST_BANK_QUIET: assert property (go && op inside {8'h4F, 8'h5F} |=>
    (!rf_we && !mem_rd)[*4]) else $error("bank select touched memory");
  AST_SHORT_DONE: assert property (go && op inside {8'hCF, 8'h4F, 8'h5F}
    |=> busy[*4] ##1 !busy) else $error("one byte op length");
  AST_RET_FETCH: assert property (go && op == 8'hAF |-> ##[0:3] mem_rd)
    else $error("return did not read stack");
  AST_RET_ORDER: assert property (mem_rd && $past(mem_rd) |->
    mem_addr == $past(mem_addr) + 16'h0001) else $error("stack order");
  AST_RET_DONE: assert property (go && op == 8'hAF |=> busy[*5] ##[1:6]
    !busy) else $error("return length");
  AST_ROT_WRITE: assert property (go && rot |-> ##[1:6] rf_we)
    else $error("rotate wrote no result");
  AST_ROT_NO_STACK: assert property (go && rot |=> (!mem_rd)[*4])
    else $error("rotate read the stack");
  AST_WE_PULSE: assert property (rf_we |-> busy ##1 !rf_we)
    else $error("register write not a single pulse");
  COV_RET: cover property (mem_rd ##1 mem_rd);
  COV_ROT: cover property (go && rot ##[1:6] rf_we);
  COV_BANK: cover property (go && op == 8'h5F);
endmodule
bind rrbx_exec rrbx_exec_checker rrbx_exec_checker_i
(
  .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr), .mem_rd(mem_rd),
  .rf_we(rf_we), .busy(busy)
);

/* rrbx_exec_tb_top.sv */
// Self-checking bench for the execution unit.
`timescale 1ns/1ns
module rrbx_exec_tb_top;
  import rrbx_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] mem_addr;
  logic mem_rd;
  logic [7:0] mem_rdata;
  logic [7:0] rf_addr;
  logic rf_we;
  logic [7:0] rf_wdata;
  logic [7:0] rf_rdata;
  logic busy;
  logic [7:0] rf [256];
  logic [7:0] stk [256];
  logic [31:0] seed = 32'h12;
  int mismatches = 0;
  int check_count = 0;
  localparam logic [7:0] ROT [4] = '{8'h90, 8'h10, 8'hE0, 8'hC0};
  localparam logic [7:0] ONE [3] = '{8'hCF, 8'h5F, 8'h4F};
  ////////////////////////////////////////////////////////////////////////
  always #25 sys_clk = ~sys_clk;
  assign rf_rdata = rf[rf_addr];
  always @(posedge sys_clk)
  begin
    if (rf_we)
      rf[rf_addr] <= rf_wdata;
  end
  // The stack answers in the cycle of the read strobe, as the return
  // sequence samples it; with no strobe it shows the inverse.
  assign mem_rdata = mem_rd ? stk[mem_addr[7:0]] : ~stk[mem_addr[7:0]];
  rrbx_exec rrbx_exec_i
  (
    .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .rf_addr(rf_addr), .rf_we(rf_we), .rf_wdata(rf_wdata),
    .rf_rdata(rf_rdata), .busy(busy)
  );
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [15:0] rot_exp(input logic [7:0] op,
    input logic [7:0] v, input logic [7:0] fl);
    logic [7:0] r;
    case (op & 8'hFE)
      8'h90: r = {v[6:0], v[7]};
      8'h10: r = {v[6:0], fl[7]};
      8'hE0: r = {v[0], v[7:1]};
      default: r = {fl[7], v[7:1]};
    endcase
    return {r, op[6] ? v[0] : v[7], r == 8'h00, r[7], r[7] ^ v[7], fl[3:0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    mismatches += (n >= 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic settle(output int n);
    n = 0;
    while (busy !== 1'b0 && n < 40)
    begin
      @(posedge sys_clk);
      n++;
    end
    mismatches += (n >= 40);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] q;
    int n;
    logic [15:0] res;
    logic [15:0] sp;
    logic [7:0] fl, v, p, t, op, hi, lo;
    for (int i = 0; i < 256; i++)
    begin
      rf[i] = rnd();
      stk[i] = rnd();
    end
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    acc(1'b0, RRBX_ADDR_FLAGS, 32'h0, q);
    chk("flags_reset", q, {24'h0, RRBX_FLAGS_RESET});
    acc(1'b0, RRBX_ADDR_PC, 32'h0, q);
    chk("pc_reset", q, {RRBX_SP_RESET, RRBX_PC_RESET});
    acc(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", q, RRBX_UNMAPPED);
    for (int i = 0; i < 32; i++)
    begin
      op = ROT[i % 4] | {7'h00, i[2]};
      fl = rnd();
      v = (i < 4) ? {i[0], 7'h00} : rnd();
      p = rnd();
      t = op[0] ? p ^ 8'h5A : p;
      rf[p] = op[0] ? t : v;
      rf[t] = v;
      acc(1'b1, RRBX_ADDR_FLAGS, {24'h0, fl}, q);
      acc(1'b1, RRBX_ADDR_CTRL, {16'h0, p, op}, q);
      settle(n);
      chk("rot_cycles", n, RRBX_CYC_SHORT);
      res = rot_exp(op, v, fl);
      chk("rot_value", rf[t], res[15:8]);
      acc(1'b0, RRBX_ADDR_FLAGS, 32'h0, q);
      chk("rot_flags", q[7:0], res[7:0]);
    end
    for (int j = 0; j < 6; j++)
    begin
      fl = rnd();
      acc(1'b1, RRBX_ADDR_FLAGS, {24'h0, fl}, q);
      acc(1'b1, RRBX_ADDR_CTRL, {16'h0, rnd(), ONE[j % 3]}, q);
      settle(n);
      chk("one_byte_cycles", n, RRBX_CYC_SHORT);
      acc(1'b0, RRBX_ADDR_FLAGS, 32'h0, q);
      v = (j % 3 == 0) ? fl & 8'h7F : (j % 3 == 1) ? fl | 8'h01 : fl & 8'hFE;
      chk("one_byte_flags", q[7:0], v);
    end
    for (int k = 0; k < 2; k++)
    begin
      sp = {8'h00, rnd() & 8'hFE};
      hi = rnd();
      lo = rnd();
      stk[sp[7:0]] = hi;
      stk[sp[7:0] + 8'h01] = lo;
      fl = rnd();
      acc(1'b1, RRBX_ADDR_FLAGS, {24'h0, fl}, q);
      acc(1'b1, RRBX_ADDR_PC, {sp, 16'h1234}, q);
      acc(1'b1, RRBX_ADDR_CTRL, {16'h0, 8'h00, RRBX_OP_RETURN}, q);
      // A new opcode while busy must be dropped; the first pass times the
      // return on its own instead.
      v = rf[8'h33];
      if (k == 1)
        acc(1'b1, RRBX_ADDR_CTRL, {16'h0, 8'h33, RRBX_OP_ROT_LEFT}, q);
      settle(n);
      chk("busy_drop", rf[8'h33], v);
      if (k == 0)
        chk("ret_cycles", n, RRBX_CYC_RET_INT);
      acc(1'b0, RRBX_ADDR_PC, 32'h0, q);
      chk("ret_pc_sp", q, {sp + RRBX_STACK_STEP, hi, lo});
      acc(1'b0, RRBX_ADDR_FLAGS, 32'h0, q);
      chk("ret_flags", q[7:0], fl);
    end
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
